// *** src/clm_logic_modules.sv ***
// Four configurable logic cells with source selection and periodic passes.
// Assumes synchronous inputs, a single clock and a plain register port.
// Assumes that step and clear are write-only pulses in the control register.
// Behaviour
// - Four identical cells, each with its own mode and two source selects.
// - Each cell has two binary inputs and one output, inputs freely selectable.
// - Any cell output can be selected as a source for other cells.
// - Cells evaluate in ascending order; lower results visible to higher in pass.
// - Mode 0 holds the output at 0.
// - Mode 1 gives the AND of both inputs.
// - Mode 2 gives the OR of both inputs.
// - Mode 3 gives the XOR of both inputs.
// - Mode 10 is a latch: first sets, second resets, both low holds.
// - In latch mode both inputs high give output 0.
// - Mode 20 toggles on each rising edge of the first input only.
// - In toggle mode the second input has no effect.
// - Mode 30 loads the first input on a rising edge of the second.
// - In data mode the output holds except on a second-input rising edge.
// - Every cell output is available to other logic and to outside pins.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module clm_logic_modules #(
   parameter int unsigned PASS_CYC = clm_pkg::PASS_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Signal sources and external processing tick
   input wire logic [15:0] ext_src_i,
   input wire logic tick_i,
   // Results
   output logic [3:0] cell_q_o,
   output logic pass_done_o
);

   // The pass timer counts one full processing period in clock cycles.
   localparam int unsigned TMR_W = $clog2(PASS_CYC + 1);
   localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(PASS_CYC - 1);

   // Configuration and control state.
   clm_pkg::clm_cfg_t cfg_r [clm_pkg::NUM_CELLS];
   clm_pkg::clm_cfg_t cfg_nxt [clm_pkg::NUM_CELLS];
   logic run_r;
   logic run_nxt;
   logic ext_tick_r;
   logic ext_tick_nxt;

   // Cell state.
   logic [3:0] q_r;
   logic [3:0] q_nxt;
   clm_pkg::clm_pair_t prev_r [clm_pkg::NUM_CELLS];
   clm_pkg::clm_pair_t prev_nxt [clm_pkg::NUM_CELLS];

   // Pass scheduling.
   logic [TMR_W-1:0] tmr_r;
   logic [TMR_W-1:0] tmr_nxt;
   logic [7:0] pass_cnt_r;
   logic [7:0] pass_cnt_nxt;
   logic pass_done_r;
   logic pass_done_nxt;

   // Read data.
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   // Combinational results of the current pass.
   logic [3:0] q_eval;
   logic [3:0] first_in;
   logic [3:0] second_in;
   logic [3:0] view [clm_pkg::NUM_CELLS];
   logic tmr_hit;
   logic step_req;
   logic clear_req;
   logic pass_go;
   logic ctrl_wr;

   // Picks one source bit from the external sources or the cell outputs.
   // Codes above the last cell output read as constant zero.
   function automatic logic pick_src(
      input logic [4:0] sel,
      input logic [15:0] ext,
      input logic [3:0] cells
   );
      logic bit_val;
      bit_val = 1'b0;
      if (sel < clm_pkg::SEL_CELL_BASE) begin
         bit_val = ext[sel[3:0]];
      end else if (sel <= clm_pkg::SEL_CELL_LAST) begin
         bit_val = cells[sel[1:0]];
      end
      return bit_val;
   endfunction

   // ------------------------------------------------------------------
   // Cell evaluation chain.
   // ------------------------------------------------------------------

   // Each cell sees the fresh results of lower cells and the stored
   // results of itself and higher cells, so the order is fixed by number.
   genvar gk;
   genvar gj;
   generate
      for (gk = 0; gk < clm_pkg::NUM_CELLS; gk++) begin : g_cell
         for (gj = 0; gj < clm_pkg::NUM_CELLS; gj++) begin : g_view
            if (gj < gk) begin : g_new
               assign view[gk][gj] = q_eval[gj];
            end else begin : g_old
               assign view[gk][gj] = q_r[gj];
            end
         end

         assign first_in[gk] = pick_src(cfg_r[gk].sel1, ext_src_i, view[gk]);
         assign second_in[gk] = pick_src(cfg_r[gk].sel2, ext_src_i, view[gk]);

         // The cell only computes; the state that it reads is held here.
         clm_cell u_cell (
            .mode_i(cfg_r[gk].mode),
            .first_i(first_in[gk]),
            .second_i(second_in[gk]),
            .first_prev_i(prev_r[gk].first),
            .second_prev_i(prev_r[gk].second),
            .q_i(q_r[gk]),
            .q_nxt_o(q_eval[gk])
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // Pass scheduling.
   // ------------------------------------------------------------------

   // Step and clear act only in the cycle of the control write.
   assign ctrl_wr = reg_wr_i && (reg_addr_i == clm_pkg::REG_CTRL);
   assign step_req = ctrl_wr && reg_wdata_i[clm_pkg::CTRL_STEP_BIT];
   assign clear_req = ctrl_wr && reg_wdata_i[clm_pkg::CTRL_CLEAR_BIT];
   assign tmr_hit = (tmr_r == TMR_LAST);

   // A pass runs on the internal timer or on the external tick, or once on
   // a software step; a clear in the same cycle suppresses the pass.
   always_comb begin
      pass_go = 1'b0;
      if (!clear_req) begin
         if (step_req) begin
            pass_go = 1'b1;
         end else if (run_r) begin
            if (ext_tick_r) begin
               pass_go = tick_i;
            end else begin
               pass_go = tmr_hit;
            end
         end
      end
   end

   // The timer only counts while it is the pass source, so selecting it always
   // starts a full period. The pass pulse marks the cycle of the new outputs.
   always_comb begin
      tmr_nxt = tmr_r;
      pass_cnt_nxt = pass_cnt_r;
      pass_done_nxt = pass_go;
      if (!run_r || ext_tick_r || tmr_hit) begin
         tmr_nxt = '0;
      end else begin
         tmr_nxt = tmr_r + TMR_W'(1);
      end
      // The pass counter wraps, so software compares two readings modulo 256.
      if (pass_go) begin
         pass_cnt_nxt = pass_cnt_r + 8'h01;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tmr_r <= '0;
         pass_cnt_r <= 8'h00;
         pass_done_r <= 1'b0;
      end else begin
         tmr_r <= tmr_nxt;
         pass_cnt_r <= pass_cnt_nxt;
         pass_done_r <= pass_done_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Cell state update.
   // ------------------------------------------------------------------

   // A clear wipes the outputs and the stored samples. A pass stores the new
   // outputs and the inputs that made them, the previous samples of the next pass.
   always_comb begin
      q_nxt = q_r;
      for (int k = 0; k < clm_pkg::NUM_CELLS; k++) begin
         prev_nxt[k] = prev_r[k];
      end
      if (clear_req) begin
         q_nxt = 4'h0;
         for (int k = 0; k < clm_pkg::NUM_CELLS; k++) begin
            prev_nxt[k] = '0;
         end
      end else if (pass_go) begin
         q_nxt = q_eval;
         for (int k = 0; k < clm_pkg::NUM_CELLS; k++) begin
            prev_nxt[k].first = first_in[k];
            prev_nxt[k].second = second_in[k];
         end
      end
   end

   // Reset clears the cell outputs and the stored samples.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q_r <= 4'h0;
         for (int k = 0; k < clm_pkg::NUM_CELLS; k++) begin
            prev_r[k] <= '0;
         end
      end else begin
         q_r <= q_nxt;
         for (int k = 0; k < clm_pkg::NUM_CELLS; k++) begin
            prev_r[k] <= prev_nxt[k];
         end
      end
   end

   // ------------------------------------------------------------------
   // Register writes.
   // ------------------------------------------------------------------

   // Each cell owns one mode, one first-select and one second-select address.
   // A control write sets run and tick source together; step and clear are not stored.
   always_comb begin
      run_nxt = run_r;
      ext_tick_nxt = ext_tick_r;
      for (int k = 0; k < clm_pkg::NUM_CELLS; k++) begin
         cfg_nxt[k] = cfg_r[k];
      end
      if (reg_wr_i) begin
         for (int k = 0; k < clm_pkg::NUM_CELLS; k++) begin
            if (reg_addr_i == clm_pkg::REG_MODE_BASE + 8'(k)) begin
               cfg_nxt[k].mode = reg_wdata_i;
            end
            if (reg_addr_i == clm_pkg::REG_SEL1_BASE + 8'(k)) begin
               cfg_nxt[k].sel1 = reg_wdata_i[4:0];
            end
            if (reg_addr_i == clm_pkg::REG_SEL2_BASE + 8'(k)) begin
               cfg_nxt[k].sel2 = reg_wdata_i[4:0];
            end
         end
         if (ctrl_wr) begin
            run_nxt = reg_wdata_i[clm_pkg::CTRL_RUN_BIT];
            ext_tick_nxt = reg_wdata_i[clm_pkg::CTRL_EXT_TICK_BIT];
         end
      end
   end

   // Configuration resets to mode off with both selects on the first source.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         run_r <= clm_pkg::RUN_RST;
         ext_tick_r <= clm_pkg::EXT_TICK_RST;
         for (int k = 0; k < clm_pkg::NUM_CELLS; k++) begin
            cfg_r[k].mode <= clm_pkg::MODE_RST;
            cfg_r[k].sel1 <= clm_pkg::SEL_RST;
            cfg_r[k].sel2 <= clm_pkg::SEL_RST;
         end
      end else begin
         run_r <= run_nxt;
         ext_tick_r <= ext_tick_nxt;
         for (int k = 0; k < clm_pkg::NUM_CELLS; k++) begin
            cfg_r[k] <= cfg_nxt[k];
         end
      end
   end

   // ------------------------------------------------------------------
   // Register reads.
   // ------------------------------------------------------------------

   // Read data stand only in the cycle after the read strobe.
   // Selects read back in their low five bits and unmapped addresses read as zero.
   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_rd_i) begin
         for (int k = 0; k < clm_pkg::NUM_CELLS; k++) begin
            if (reg_addr_i == clm_pkg::REG_MODE_BASE + 8'(k)) begin
               rdata_nxt = cfg_r[k].mode;
            end
            if (reg_addr_i == clm_pkg::REG_SEL1_BASE + 8'(k)) begin
               rdata_nxt = {3'h0, cfg_r[k].sel1};
            end
            if (reg_addr_i == clm_pkg::REG_SEL2_BASE + 8'(k)) begin
               rdata_nxt = {3'h0, cfg_r[k].sel2};
            end
         end
         unique case (reg_addr_i)
            clm_pkg::REG_CTRL: begin
               rdata_nxt[clm_pkg::CTRL_RUN_BIT] = run_r;
               rdata_nxt[clm_pkg::CTRL_EXT_TICK_BIT] = ext_tick_r;
            end
            clm_pkg::REG_STATUS: rdata_nxt = {4'h0, q_r};
            clm_pkg::REG_PASS_CNT: rdata_nxt = pass_cnt_r;
            clm_pkg::REG_EXT_LO: rdata_nxt = ext_src_i[7:0];
            clm_pkg::REG_EXT_HI: rdata_nxt = ext_src_i[15:8];
            clm_pkg::REG_SAMPLE: begin
               rdata_nxt = {prev_r[3].second,
                            prev_r[3].first,
                            prev_r[2].second,
                            prev_r[2].first,
                            prev_r[1].second,
                            prev_r[1].first,
                            prev_r[0].second,
                            prev_r[0].first};
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Outputs.
   // ------------------------------------------------------------------

   // Every output comes from a register, so no input reaches an output in one cycle.
   assign reg_rdata_o = rdata_r;
   assign cell_q_o = q_r;
   assign pass_done_o = pass_done_r;

endmodule // clm_logic_modules

// *** inc/clm_pkg.sv ***
// Shared constants and types for the four configurable logic cells.
// Assumes a single 100 MHz clock and an 8-bit register port.
package clm_pkg;

   // Structure of the block.
   localparam int unsigned NUM_CELLS = 4;
   localparam int unsigned EXT_W = 16;
   localparam int unsigned SEL_W = 5;
   localparam int unsigned MODE_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // Cell mode codes.
   localparam logic [7:0] MODE_OFF = 8'h00;
   localparam logic [7:0] MODE_AND = 8'h01;
   localparam logic [7:0] MODE_OR = 8'h02;
   localparam logic [7:0] MODE_XOR = 8'h03;
   localparam logic [7:0] MODE_RS = 8'h0a;
   localparam logic [7:0] MODE_TOG = 8'h14;
   localparam logic [7:0] MODE_DFF = 8'h1e;

   // Source select codes: 0 to 15 external sources, 16 to 19 cell outputs.
   localparam logic [4:0] SEL_CELL_BASE = 5'h10;
   localparam logic [4:0] SEL_CELL_LAST = 5'h13;

   // Register offsets.
   localparam logic [7:0] REG_MODE_BASE = 8'h00;
   localparam logic [7:0] REG_SEL1_BASE = 8'h04;
   localparam logic [7:0] REG_SEL2_BASE = 8'h08;
   localparam logic [7:0] REG_CTRL = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h0d;
   localparam logic [7:0] REG_PASS_CNT = 8'h0e;
   localparam logic [7:0] REG_EXT_LO = 8'h0f;
   localparam logic [7:0] REG_EXT_HI = 8'h10;
   localparam logic [7:0] REG_SAMPLE = 8'h11;

   // Control register fields.
   localparam int unsigned CTRL_RUN_BIT = 0;
   localparam int unsigned CTRL_EXT_TICK_BIT = 1;
   localparam int unsigned CTRL_STEP_BIT = 2;
   localparam int unsigned CTRL_CLEAR_BIT = 3;

   // Values after reset.
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [4:0] SEL_RST = 5'h00;
   localparam logic RUN_RST = 1'b1;
   localparam logic EXT_TICK_RST = 1'b0;

   // Processing period.
   localparam int unsigned CLK_HZ = 100000000;
   localparam int unsigned PASS_PERIOD_MS = 16;
   localparam int unsigned PASS_CYCLES = PASS_PERIOD_MS * (CLK_HZ / 1000);

   typedef struct packed {
      logic [7:0] mode;
      logic [4:0] sel1;
      logic [4:0] sel2;
   } clm_cfg_t;

   typedef struct packed {
      logic first;
      logic second;
   } clm_pair_t;

endpackage

// *** src/clm_cell.sv ***
// One logic cell: computes its output for the current processing pass.
// Assumes the caller holds the output and the previous input samples.
`timescale 1ns/1ns
module clm_cell (
   // Configuration
   input wire logic [7:0] mode_i,
   // Inputs of this pass and of the previous pass
   input wire logic first_i,
   input wire logic second_i,
   input wire logic first_prev_i,
   input wire logic second_prev_i,
   // Output state
   input wire logic q_i,
   output logic q_nxt_o
);

   logic rise_first;
   logic rise_second;

   always_comb begin
      rise_first = first_i & ~first_prev_i;
      rise_second = second_i & ~second_prev_i;
      q_nxt_o = 1'b0;
      unique case (mode_i)
         clm_pkg::MODE_OFF: q_nxt_o = 1'b0;
         clm_pkg::MODE_AND: q_nxt_o = first_i & second_i;
         clm_pkg::MODE_OR: q_nxt_o = first_i | second_i;
         clm_pkg::MODE_XOR: q_nxt_o = first_i ^ second_i;
         clm_pkg::MODE_RS: begin
            // Reset has priority over set.
            if (second_i) begin
               q_nxt_o = 1'b0;
            end else if (first_i) begin
               q_nxt_o = 1'b1;
            end else begin
               q_nxt_o = q_i;
            end
         end
         clm_pkg::MODE_TOG: begin
            // The second input is not looked at in this mode.
            q_nxt_o = rise_first ? ~q_i : q_i;
         end
         clm_pkg::MODE_DFF: begin
            q_nxt_o = rise_second ? first_i : q_i;
         end
         default: q_nxt_o = 1'b0;
      endcase
   end

endmodule // clm_cell

// *** dv/clm_src_model.sv ***
// Model of the drive terminals and control tick that feed the logic cells.
// Assumes the bench sets levels and tick requests just after rising edges.
`timescale 1ns/1ns
module clm_src_model (
   // Clock
   input wire logic clk_i,
   // Requests from the bench
   input wire logic [15:0] level_i,
   input wire logic tick_req_i,
   // Terminal levels and processing tick
   output logic [15:0] ext_o = 16'h0000,
   output logic tick_o = 1'b0
);
   // Terminals are resampled every clock, so the cells only ever see synchronous levels.
   always @(posedge clk_i) begin
      ext_o <= level_i;
      tick_o <= tick_req_i;
   end
endmodule // clm_src_model

// *** dv/clm_logic_monitor.sv ***
// Checker for the logic cells: register read timing, pass timing and cell zero results.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module clm_logic_monitor #(
   parameter int unsigned PASS_CYC = clm_pkg::PASS_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // Sources and tick
   input wire logic [15:0] ext_src_i,
   input wire logic tick_i,
   // Results
   input wire logic [3:0] cell_q_o,
   input wire logic pass_done_o
);
   logic [7:0] mode0_r;
   logic [4:0] s1_r;
   logic [4:0] s2_r;
   logic run_r;
   logic xt_r;
   logic ws_r;
   localparam int unsigned GW = $clog2(PASS_CYC) + 1;
   logic [GW-1:0] gap_r;
   logic ctl_w;
   logic clr_w;
   logic ok;
   logic f1;
   logic f2;
   assign ctl_w = reg_wr_i && reg_addr_i == clm_pkg::REG_CTRL;
   assign clr_w = ctl_w && reg_wdata_i[3];
   assign ok = !s1_r[4] && !s2_r[4];
   assign f1 = ext_src_i[s1_r[3:0]];
   assign f2 = ext_src_i[s2_r[3:0]];
   // Mirrors of cell zero and control; ws_r marks a period disturbed by a control write.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode0_r <= 8'h00;
         s1_r <= 5'h00;
         s2_r <= 5'h00;
         run_r <= 1'b1;
         xt_r <= 1'b0;
         ws_r <= 1'b1;
         gap_r <= '1;
      end else begin
         if (reg_wr_i && reg_addr_i == clm_pkg::REG_MODE_BASE) mode0_r <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == clm_pkg::REG_SEL1_BASE) s1_r <= reg_wdata_i[4:0];
         if (reg_wr_i && reg_addr_i == clm_pkg::REG_SEL2_BASE) s2_r <= reg_wdata_i[4:0];
         if (ctl_w) run_r <= reg_wdata_i[0];
         if (ctl_w) xt_r <= reg_wdata_i[1];
         ws_r <= ctl_w || (ws_r && !pass_done_o);
         gap_r <= pass_done_o ? '0 : gap_r + GW'(gap_r != '1);
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data not zero outside read answer");
   a_status_read: assert property ($past(reg_rd_i && reg_addr_i == clm_pkg::REG_STATUS)
      |-> reg_rdata_o == {4'h0, $past(cell_q_o)}) else $error("status read wrong");
   a_step_pass: assert property (ctl_w && reg_wdata_i[2] && !reg_wdata_i[3] |=> pass_done_o)
      else $error("step write gave no pass");
   a_clear_cells: assert property (clr_w |=> cell_q_o == 4'h0 && !pass_done_o)
      else $error("clear did not zero cells");
   a_q_at_pass: assert property ($changed(cell_q_o) |-> pass_done_o || $past(clr_w))
      else $error("cell output moved between passes");
   a_timer_gap: assert property (pass_done_o && !ws_r && run_r && !xt_r
      |-> gap_r == GW'(PASS_CYC - 1)) else $error("timer pass spacing wrong");
   a_tick_pass: assert property (run_r && xt_r && tick_i && !ctl_w |=> pass_done_o)
      else $error("tick gave no pass");
   a_off_zero: assert property (pass_done_o && $past(mode0_r) == clm_pkg::MODE_OFF
      |-> !cell_q_o[0]) else $error("off cell not zero");
   a_and_cell: assert property (pass_done_o && $past(mode0_r == clm_pkg::MODE_AND && ok)
      |-> cell_q_o[0] == $past(f1 & f2)) else $error("and cell wrong");
   a_xor_cell: assert property (pass_done_o && $past(mode0_r == clm_pkg::MODE_XOR && ok)
      |-> cell_q_o[0] == $past(f1 ^ f2)) else $error("xor cell wrong");
   a_latch_reset: assert property (pass_done_o
      && $past(mode0_r == clm_pkg::MODE_RS && ok && f1 && f2) |-> !cell_q_o[0])
      else $error("latch with both inputs high not zero");
   c_toggle: cover property (pass_done_o && mode0_r == clm_pkg::MODE_TOG);
   c_timer: cover property (pass_done_o && run_r && !xt_r && !ws_r);
   c_tick: cover property (pass_done_o && xt_r);
endmodule // clm_logic_monitor
bind clm_logic_modules clm_logic_monitor #(.PASS_CYC(PASS_CYC)) u_clm_logic_monitor (
   .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .ext_src_i(ext_src_i), .tick_i(tick_i), .cell_q_o(cell_q_o), .pass_done_o(pass_done_o));

// *** dv/tb_clm_logic_modules.sv ***
// Testbench of the logic cells: register tasks, stepped passes, timer and tick passes.
// Assumes the design package is compiled first; the pass period is shortened to 20 cycles.
`timescale 1ns/1ns
module tb_clm_logic_modules;
   localparam int unsigned PC = 20;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic [15:0] ext_src_i;
   logic tick_i;
   logic [3:0] cell_q_o;
   logic pass_done_o;
   logic [15:0] lvl = 16'h0000;
   logic pul = 1'b0;
   logic [7:0] rd;
   int miscompares = 0;
   int checks_done = 0;
   int np = 0;
   int n0;
   int n;
   clm_src_model u_clm_src_model (.clk_i(clk_i), .level_i(lvl), .tick_req_i(pul),
      .ext_o(ext_src_i), .tick_o(tick_i));
   clm_logic_modules #(.PASS_CYC(PC)) u_clm_logic_modules (.clk_i(clk_i), .rst_i(rst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ext_src_i(ext_src_i),
      .tick_i(tick_i), .cell_q_o(cell_q_o), .pass_done_o(pass_done_o));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (pass_done_o === 1'b1) np <= np + 1;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask
   // Sets the terminals, lets them settle, takes one stepped pass and checks all cells.
   task automatic stp(input logic [15:0] v, input logic [3:0] e);
      lvl <= v;
      repeat (2) @(posedge clk_i);
      wr(clm_pkg::REG_CTRL, 8'h04);
      @(posedge clk_i);
      #1 chk({4'h0, cell_q_o}, {4'h0, e});
   endtask
   // Runs cell zero through six passes after a clear; two bits of vs per pass.
   task automatic seq(input logic [7:0] md, input logic [11:0] vs, input logic [5:0] es);
      int i;
      wr(clm_pkg::REG_CTRL, 8'h08);
      wr(clm_pkg::REG_MODE_BASE, md);
      for (i = 0; i < 6; i++) stp(16'(vs[2 * i +: 2]), {3'h0, es[i]});
   endtask
   initial begin
      #200000;
      miscompares++;
      end_of_test();
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      // The timer runs from reset, so one timed pass is counted before offset 14 is read.
      for (n = 0; n < 19; n++) begin
         rdr(8'(n), rd);
         chk(rd, (n == 12 || n == 14) ? 8'h01 : 8'h00);
      end
      wr(clm_pkg::REG_CTRL, 8'h00);
      wr(clm_pkg::REG_SEL2_BASE, 8'h01);
      for (n = 0; n < 16; n++) begin
         if (n % 4 == 0) wr(clm_pkg::REG_MODE_BASE, 8'(n / 4));
         stp(16'(n % 4), 4'((16'h6e80 >> n) & 16'h0001));
      end
      seq(clm_pkg::MODE_RS, 12'h271, 6'h0b);
      seq(clm_pkg::MODE_TOG, 12'h92d, 6'h0f);
      seq(clm_pkg::MODE_DFF, 12'h62d, 6'h0e);
      wr(clm_pkg::REG_MODE_BASE, clm_pkg::MODE_AND);
      for (n = 1; n < 4; n++) begin
         wr(8'(n), 8'(32'h02030200 >> (8 * n)));
         wr(8'(4 + n), 8'(32'h12131000 >> (8 * n)));
         wr(8'(8 + n), 8'(32'h14111400 >> (8 * n)));
      end
      wr(clm_pkg::REG_CTRL, 8'h08);
      stp(16'h0003, 4'hf);
      stp(16'h0003, 4'h3);
      stp(16'h0003, 4'hf);
      rdr(clm_pkg::REG_STATUS, rd);
      chk(rd, 8'h0f);
      wr(clm_pkg::REG_CTRL, 8'h01);
      repeat (2 * PC) @(posedge clk_i);
      n0 = np;
      repeat (10 * PC) @(posedge clk_i);
      chk(8'(np - n0), 8'h0a);
      wr(clm_pkg::REG_CTRL, 8'h03);
      n0 = np;
      repeat (3) begin
         pul <= 1'b1;
         @(posedge clk_i);
         pul <= 1'b0;
         repeat (PC + 3) @(posedge clk_i);
      end
      chk(8'(np - n0), 8'h03);
      wr(clm_pkg::REG_CTRL, 8'h0b);
      @(posedge clk_i);
      #1 chk({4'h0, cell_q_o}, 8'h00);
      rdr(clm_pkg::REG_SAMPLE, rd);
      chk(rd, 8'h00);
      end_of_test();
   end
endmodule // tb_clm_logic_modules
